// >>> design/auart_top.sv
// full-duplex async serial transceiver with an axi4-lite register slave
// assumes one 10 MHz clock; the receive pin is asynchronous to it
`timescale 1ns/10ps
`include "auart_cfg.svh"

module auart_top
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial pins
  input  wire logic        rxdPin,
  output logic             txdPin,
  output logic             txdPinOe,
  // interrupt request
  output logic             irqReq
);

  auart_pkg::auart_state_type s_q;
  auart_pkg::auart_state_type s_d;

  // =====================================================================
  // helpers
  function automatic logic [15:0] baudDivisor(input logic [4:0] sel);
    logic [15:0] presc;
    presc = `AUART_PRESC0;
    case (sel[4:3])
      2'b01:   presc = `AUART_PRESC1;
      2'b10:   presc = `AUART_PRESC2;
      2'b11:   presc = `AUART_PRESC3;
      default: presc = `AUART_PRESC0;
    endcase
    return presc << sel[2:0];
  endfunction

  function automatic logic majority(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `AUART_OFS_BAUD || a == `AUART_OFS_CTRL1 ||
           a == `AUART_OFS_CTRL2 || a == `AUART_OFS_FLAGS ||
           a == `AUART_OFS_DATA;
  endfunction

  // =====================================================================
  // next state
  always_comb
  begin
    logic        doWrite;
    logic        doRead;
    logic        wrData;
    logic        rdData;
    logic        tick;
    logic        bitTick;
    logic        te;
    logic        re;
    logic        loaded;
    logic        bitVal;
    logic        msb;
    logic        sleepEff;
    logic [3:0]  frameLen;
    logic [7:0]  idleTarget;
    logic [8:0]  rxChar;
    logic [7:0]  rdByte;
    doWrite    = 1'b0;
    doRead     = 1'b0;
    wrData     = 1'b0;
    rdData     = 1'b0;
    tick       = 1'b0;
    bitTick    = 1'b0;
    te         = 1'b0;
    re         = 1'b0;
    loaded     = 1'b0;
    bitVal     = 1'b0;
    msb        = 1'b0;
    sleepEff   = 1'b0;
    frameLen   = `AUART_FRAME8;
    idleTarget = 8'h00;
    rxChar     = 9'h000;
    rdByte     = 8'h00;
    s_d        = s_q;

    // ---- bus slave: address and data taken in either order
    if (s_axi_awvalid && s_q.awReady)
    begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wReady)
    begin
      s_d.wHeld  = 1'b1;
      s_d.wData  = s_axi_wdata[7:0];
      s_d.wLane0 = s_axi_wstrb[0];
    end
    if (s_q.bValid && s_axi_bready)
      s_d.bValid = 1'b0;
    if (s_q.rValid && s_axi_rready)
      s_d.rValid = 1'b0;
    doWrite = s_q.awHeld && s_q.wHeld && !s_q.bValid;
    doRead  = s_axi_arvalid && s_q.arReady;
    wrData  = doWrite && s_q.wLane0 && s_q.awAddr == `AUART_OFS_DATA;
    rdData  = doRead && s_axi_araddr == `AUART_OFS_DATA;

    if (doWrite)
    begin
      s_d.awHeld = 1'b0;
      s_d.wHeld  = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp  = mapped(s_q.awAddr) ? `AUART_RESP_OKAY : `AUART_RESP_ERR;
      if (s_q.wLane0)
      begin
        unique case (s_q.awAddr)
          `AUART_OFS_BAUD:  s_d.baud = s_q.wData[4:0];
          `AUART_OFS_CTRL1:
          begin
            s_d.t8       = s_q.wData[`AUART_C1_T8];
            s_d.mode9    = s_q.wData[`AUART_C1_MODE9];
            s_d.wakeAddr = s_q.wData[`AUART_C1_WAKE];
          end
          `AUART_OFS_CTRL2: s_d.ctrl2 = s_q.wData;
          `AUART_OFS_FLAGS:
          begin
            // write one to clear; the hardware sets below still win
            if (s_q.wData[`AUART_F_TXD])
              s_d.txd = 1'b0;
            if (s_q.wData[`AUART_F_IDLE])
              s_d.idle = 1'b0;
            if (s_q.wData[`AUART_F_OVR])
              s_d.ovr = 1'b0;
            if (s_q.wData[`AUART_F_NOISE])
              s_d.noise = 1'b0;
            if (s_q.wData[`AUART_F_FRAME])
              s_d.frame = 1'b0;
          end
          `AUART_OFS_DATA:
          begin
            s_d.txHold = s_q.wData;
            s_d.txe    = 1'b0;
            s_d.txd    = 1'b0;
          end
          default: ;
        endcase
      end
    end

    if (doRead)
    begin
      unique case (s_axi_araddr)
        `AUART_OFS_BAUD:  rdByte = {3'h0, s_q.baud};
        `AUART_OFS_CTRL1: rdByte = {s_q.rxData[8], s_q.t8, 1'b0, s_q.mode9,
                                    s_q.wakeAddr, 3'h0};
        `AUART_OFS_CTRL2: rdByte = s_q.ctrl2;
        `AUART_OFS_FLAGS: rdByte = {s_q.txe, s_q.txd, s_q.rxf, s_q.idle,
                                    s_q.ovr, s_q.noise, s_q.frame, 1'b0};
        `AUART_OFS_DATA:  rdByte = s_q.ctrl2[`AUART_C2_RXON] ?
                                   s_q.rxData[7:0] : 8'h00;
        default:          rdByte = 8'h00;
      endcase
      s_d.rData  = {24'h000000, rdByte};
      s_d.rResp  = mapped(s_axi_araddr) ? `AUART_RESP_OKAY : `AUART_RESP_ERR;
      s_d.rValid = 1'b1;
      if (rdData)
        s_d.rxf = 1'b0;
    end

    // ---- shared rate: one sample tick, sixteen per bit
    te       = s_d.ctrl2[`AUART_C2_TXON];
    re       = s_d.ctrl2[`AUART_C2_RXON];
    frameLen = s_q.mode9 ? `AUART_FRAME9 : `AUART_FRAME8;
    if (s_q.divCnt >= baudDivisor(s_q.baud) - 16'h0001)
    begin
      s_d.divCnt = 16'h0000;
      tick       = 1'b1;
    end
    else
      s_d.divCnt = s_q.divCnt + 16'h0001;
    if (tick)
      s_d.txRt = s_q.txRt + 4'h1;
    bitTick = tick && s_q.txRt == `AUART_OVERSAMPLE;

    // ---- transmitter
    s_d.teOld = te;
    if (te && !s_q.teOld)
      s_d.txPre = 1'b1;
    if (bitTick)
    begin
      if (s_q.txBusy && s_q.txLeft != 4'h0)
      begin
        s_d.txdPin = s_q.txSh[0];
        s_d.txSh   = {1'b1, s_q.txSh[10:1]};
        s_d.txLeft = s_q.txLeft - 4'h1;
      end
      else
      begin
        loaded = 1'b1;
        if (te && s_d.txPre)
        begin
          s_d.txSh  = 11'h7ff;
          s_d.txPre = 1'b0;
        end
        else if (te && s_d.ctrl2[`AUART_C2_BRK])
          s_d.txSh = 11'h000;
        else if (te && !s_q.txe && !wrData)
        begin
          s_d.txSh = s_q.mode9 ? {1'b1, s_q.t8, s_q.txHold, 1'b0}
                               : {2'b11, s_q.txHold, 1'b0};
          s_d.txe  = 1'b1;
        end
        else
          loaded = 1'b0;
        if (loaded)
        begin
          s_d.txdPin = s_d.txSh[0];
          s_d.txSh   = {1'b1, s_d.txSh[10:1]};
          s_d.txLeft = frameLen - 4'h1;
          s_d.txBusy = 1'b1;
          s_d.txd    = 1'b0;
        end
        else
        begin
          if (s_q.txBusy)
            s_d.txd = 1'b1;
          s_d.txBusy = 1'b0;
          s_d.txdPin = 1'b1;
        end
      end
    end
    s_d.txdOe = te || s_d.txBusy;

    // ---- receiver: two-stage synchroniser, then sampling
    s_d.rxS1 = rxdPin;
    s_d.rxS2 = s_q.rxS1;
    idleTarget = {frameLen, 4'h0};
    if (tick)
    begin
      if (!s_q.rxS2)
        s_d.idleCnt = 8'h00;
      else if (s_q.idleCnt != idleTarget)
        s_d.idleCnt = s_q.idleCnt + 8'h01;
      if (s_q.rxS2)
        s_d.needHigh = 1'b0;
    end
    if (tick && s_q.rxS2 && s_q.idleCnt == idleTarget - 8'h01)
    begin
      if (s_d.ctrl2[`AUART_C2_SLEEP] && !s_q.wakeAddr)
        s_d.ctrl2[`AUART_C2_SLEEP] = 1'b0;
      else if (!s_d.ctrl2[`AUART_C2_SLEEP] && s_q.idleArm && re)
      begin
        s_d.idle    = 1'b1;
        s_d.idleArm = 1'b0;
      end
    end

    if (!re)
      s_d.rxState = auart_pkg::RX_HUNT;
    else if (tick)
    begin
      unique case (s_q.rxState)
        auart_pkg::RX_HUNT:
        begin
          if (!s_q.rxS2 && !s_q.needHigh)
          begin
            s_d.rxState = auart_pkg::RX_BITS;
            s_d.rxRt    = 4'h1;
            s_d.rxIdx   = 4'h0;
            s_d.rxNoise = 1'b0;
          end
        end
        auart_pkg::RX_BITS:
        begin
          s_d.rxRt = s_q.rxRt + 4'h1;
          // counter is the sample position less one: the detect tick is 1
          if (s_q.rxRt == `AUART_VOTE_A - 4'h1)
            s_d.votes[0] = s_q.rxS2;
          if (s_q.rxRt == `AUART_VOTE_B - 4'h1)
            s_d.votes[1] = s_q.rxS2;
          if (s_q.rxRt == `AUART_VOTE_C - 4'h1)
            s_d.votes[2] = s_q.rxS2;
          if (s_q.rxRt == `AUART_OVERSAMPLE)
          begin
            s_d.rxRt = 4'h0;
            bitVal   = majority(s_q.votes);
            if (s_q.votes != 3'b000 && s_q.votes != 3'b111)
              s_d.rxNoise = 1'b1;
            s_d.rxIdx = s_q.rxIdx + 4'h1;
            if (s_q.rxIdx == 4'h0 && bitVal)
              s_d.rxState = auart_pkg::RX_HUNT; // false start
            else if (s_q.rxIdx != frameLen - 4'h1)
              s_d.rxSh = {bitVal, s_q.rxSh[8:1]};
            else
            begin
              s_d.rxState = auart_pkg::RX_HUNT;
              rxChar = s_q.mode9 ? s_q.rxSh : {1'b0, s_q.rxSh[8:1]};
              msb    = s_q.mode9 ? rxChar[8] : rxChar[7];
              // an all-zero frame is a break: wait for a high first
              if (!bitVal && rxChar == 9'h000)
                s_d.needHigh = 1'b1;
              sleepEff = s_d.ctrl2[`AUART_C2_SLEEP];
              if (sleepEff && s_q.wakeAddr && msb)
              begin
                sleepEff = 1'b0;
                s_d.ctrl2[`AUART_C2_SLEEP] = 1'b0;
              end
              if (!sleepEff)
              begin
                s_d.idleArm = 1'b1;
                if (s_d.rxf)
                  s_d.ovr = 1'b1;
                else
                begin
                  s_d.rxData = rxChar;
                  s_d.rxf    = 1'b1;
                  if (s_d.rxNoise)
                    s_d.noise = 1'b1;
                  if (!bitVal)
                    s_d.frame = 1'b1;
                end
              end
            end
          end
        end
      endcase
    end

    // ---- handshake readiness and request line
    s_d.awReady = !s_d.awHeld && !s_d.bValid;
    s_d.wReady  = !s_d.wHeld && !s_d.bValid;
    s_d.arReady = !s_d.rValid;
    s_d.irq = (s_d.ctrl2[`AUART_C2_TXEIE] && s_d.txe) ||
              (s_d.ctrl2[`AUART_C2_TXDIE] && s_d.txd) ||
              (s_d.ctrl2[`AUART_C2_RXFIE] && (s_d.rxf || s_d.ovr)) ||
              (s_d.ctrl2[`AUART_C2_QLIE] && s_d.idle);
  end

  // =====================================================================
  // state register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q          <= '0;
      s_q.ctrl2    <= `AUART_C2_RESET;
      s_q.txe      <= 1'b1;
      s_q.txd      <= 1'b1;
      s_q.txdPin   <= 1'b1;
      s_q.rxS1     <= 1'b1;
      s_q.rxS2     <= 1'b1;
      s_q.rxState  <= auart_pkg::RX_HUNT;
    end
    else
      s_q <= s_d;
  end

  // =====================================================================
  // outputs, all straight from the state register
  assign s_axi_awready = s_q.awReady;
  assign s_axi_wready  = s_q.wReady;
  assign s_axi_bvalid  = s_q.bValid;
  assign s_axi_bresp   = s_q.bResp;
  assign s_axi_arready = s_q.arReady;
  assign s_axi_rvalid  = s_q.rValid;
  assign s_axi_rdata   = s_q.rData;
  assign s_axi_rresp   = s_q.rResp;
  assign txdPin        = s_q.txdPin;
  assign txdPinOe      = s_q.txdOe;
  assign irqReq        = s_q.irq;

endmodule

// >>> include/auart_cfg.svh
// offsets, field positions, reset values and timing counts of the uart
// included by the design and the bench; definitions only
`ifndef AUART_CFG_SVH
`define AUART_CFG_SVH

// =====================================================================
// register byte offsets
`define AUART_OFS_BAUD   8'h00
`define AUART_OFS_CTRL1  8'h04
`define AUART_OFS_CTRL2  8'h08
`define AUART_OFS_FLAGS  8'h0c
`define AUART_OFS_DATA   8'h10

// =====================================================================
// serial_ctrl_one fields
`define AUART_C1_R8      7
`define AUART_C1_T8      6
`define AUART_C1_MODE9   4
`define AUART_C1_WAKE    3

// =====================================================================
// serial_ctrl_two fields
`define AUART_C2_TXEIE   7
`define AUART_C2_TXDIE   6
`define AUART_C2_RXFIE   5
`define AUART_C2_QLIE    4
`define AUART_C2_TXON    3
`define AUART_C2_RXON    2
`define AUART_C2_SLEEP   1
`define AUART_C2_BRK     0
`define AUART_C2_RESET   8'h00

// =====================================================================
// serial_flags_reg fields
`define AUART_F_TXE      7
`define AUART_F_TXD      6
`define AUART_F_RXF      5
`define AUART_F_IDLE     4
`define AUART_F_OVR      3
`define AUART_F_NOISE    2
`define AUART_F_FRAME    1

// =====================================================================
// timing
`define AUART_OVERSAMPLE 4'hf
`define AUART_VOTE_A     4'h8
`define AUART_VOTE_B     4'h9
`define AUART_VOTE_C     4'ha
`define AUART_FRAME8     4'ha
`define AUART_FRAME9     4'hb
`define AUART_PRESC0     16'h0001
`define AUART_PRESC1     16'h0003
`define AUART_PRESC2     16'h0004
`define AUART_PRESC3     16'h000d

// =====================================================================
// bus answers
`define AUART_RESP_OKAY  2'b00
`define AUART_RESP_ERR   2'b10

`endif

// >>> include/auart_pkg.sv
// types of the uart: receiver states and the packed state record
// uses none of the macros of auart_cfg.svh
package auart_pkg;

  typedef enum logic [0:0] {
    RX_HUNT = 1'b0,
    RX_BITS = 1'b1
  } auart_rx_state_type;

  typedef struct packed {
    logic               awHeld;
    logic [7:0]         awAddr;
    logic               wHeld;
    logic [7:0]         wData;
    logic               wLane0;
    logic               awReady;
    logic               wReady;
    logic               bValid;
    logic [1:0]         bResp;
    logic               arReady;
    logic               rValid;
    logic [31:0]        rData;
    logic [1:0]         rResp;
    logic [4:0]         baud;
    logic               t8;
    logic               mode9;
    logic               wakeAddr;
    logic [7:0]         ctrl2;
    logic               txe;
    logic               txd;
    logic               rxf;
    logic               idle;
    logic               ovr;
    logic               noise;
    logic               frame;
    logic [15:0]        divCnt;
    logic [3:0]         txRt;
    logic [7:0]         txHold;
    logic [10:0]        txSh;
    logic [3:0]         txLeft;
    logic               txBusy;
    logic               txPre;
    logic               teOld;
    logic               txdPin;
    logic               txdOe;
    logic               rxS1;
    logic               rxS2;
    auart_rx_state_type rxState;
    logic [3:0]         rxRt;
    logic [3:0]         rxIdx;
    logic [2:0]         votes;
    logic [8:0]         rxSh;
    logic               rxNoise;
    logic               needHigh;
    logic [8:0]         rxData;
    logic [7:0]         idleCnt;
    logic               idleArm;
    logic               irq;
  } auart_state_type;

endpackage

// >>> tb/auart_asserts.sv
// handshake and serial-pin assertions of the uart top
// bound into auart_top; any baud setting at or below the fastest
`timescale 1ns/10ps

module auart_asserts
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rready,
  // serial
  input wire logic        txdPin,
  input wire logic        txdPinOe
);
  // ====================
  // sequences
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence sWriteTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sReadTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // a bit lasts 16 clocks at the fastest rate, so 8 is a safe floor
  sequence sLineLow;
    !txdPin [*8];
  endsequence
  sequence sLineHigh;
    txdPin [*8];
  endsequence

  // ====================
  // assertions
  AST_WR_ANSWER: assert property (sWriteTaken |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  AST_RD_ANSWER: assert property (sReadTaken |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
    else $error("read data upper bits set");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_AW_BLOCK: assert property (s_axi_bvalid |->
    !(s_axi_awready || s_axi_wready))
    else $error("write taken while answer pending");
  AST_BIT_LOW: assert property ($fell(txdPin) |-> sLineLow)
    else $error("low bit too short");
  AST_BIT_HIGH: assert property ($rose(txdPin) |-> sLineHigh)
    else $error("high bit too short");
  AST_IDLE_HIGH: assert property (!txdPinOe |-> txdPin)
    else $error("released line not high");
endmodule

bind auart_top auart_asserts chk
(
  .sys_clk(sys_clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rready(s_axi_rready),
  .txdPin(txdPin), .txdPinOe(txdPinOe)
);

// >>> tb/auart_remote.sv
// remote serial terminal facing the uart pins
// sendChar is called just after a rising clock edge
`timescale 1ns/10ps

module auart_remote
(
  // clock
  input wire logic sys_clk,
  // device pins
  input wire logic txdPin,
  input wire logic txdPinOe,
  output logic     rxdLine
);
  int         bitCycles = 16;
  logic [7:0] gotData [$];
  logic       gotStop [$];

  initial
  begin
    rxdLine = 1'b1;
  end

  // a one-cycle high gap keeps two calls from driving in one step
  task automatic sendChar(input logic [7:0] d, input logic stopBit);
    logic [9:0] frame;
    frame = {stopBit, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxdLine <= frame[i];
      repeat (bitCycles) @(posedge sys_clk);
    end
    rxdLine <= 1'b1;
    @(posedge sys_clk);
  endtask

  // samples mid-bit; preamble ones never start a capture
  always
  begin : capture
    logic [8:0] sh;
    @(negedge txdPin iff txdPinOe);
    repeat (bitCycles / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (bitCycles) @(posedge sys_clk);
      sh = {txdPin, sh[8:1]};
    end
    gotData.push_back(sh[7:0]);
    gotStop.push_back(sh[8]);
  end
endmodule

// >>> tb/async_serial_uart_tb.sv
// self-checking bench of the uart: register rows, then serial cases
// baud setting 0 for all serial cases, one serial bit is 16 clock cycles
`timescale 1ns/10ps
`include "auart_cfg.svh"

module async_serial_uart_tb;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wr;
    logic [31:0] rd;
    logic [1:0]  resp;
    logic        irq;
  } auart_row_type;

  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awAddr = 8'h00;
  logic        awValid = 1'b0;
  logic        awReady;
  logic [31:0] wData = 32'h00000000;
  logic        wValid = 1'b0;
  logic        wReady;
  logic [1:0]  bResp;
  logic        bValid;
  logic        bReady = 1'b0;
  logic [7:0]  arAddr = 8'h00;
  logic        arValid = 1'b0;
  logic        arReady;
  logic [31:0] rData;
  logic [1:0]  rResp;
  logic        rValid;
  logic        rReady = 1'b0;
  logic        rxdLine;
  logic        txdPin;
  logic        txdPinOe;
  logic        irqReq;
  logic [31:0] rv;
  logic [1:0]  rr;
  logic [1:0]  wrResp;
  int          err_total = 0;
  int          total_checks = 0;
  int          n;
  auart_row_type rows [9] = '{
    '{`AUART_OFS_BAUD, 32'h1f, 32'h1f, `AUART_RESP_OKAY, 1'b0},
    '{`AUART_OFS_BAUD, 32'h00, 32'h00, `AUART_RESP_OKAY, 1'b0},
    '{`AUART_OFS_CTRL1, 32'hff, 32'h58, `AUART_RESP_OKAY, 1'b0},
    '{`AUART_OFS_CTRL1, 32'h00, 32'h00, `AUART_RESP_OKAY, 1'b0},
    '{`AUART_OFS_CTRL2, 32'h80, 32'h80, `AUART_RESP_OKAY, 1'b1},
    '{`AUART_OFS_CTRL2, 32'h40, 32'h40, `AUART_RESP_OKAY, 1'b1},
    '{`AUART_OFS_CTRL2, 32'h20, 32'h20, `AUART_RESP_OKAY, 1'b0},
    '{`AUART_OFS_CTRL2, 32'h00, 32'h00, `AUART_RESP_OKAY, 1'b0},
    '{8'h14, 32'hff, 32'h00, `AUART_RESP_ERR, 1'b0}};

  always #50 sys_clk = ~sys_clk;

  auart_top dut
  (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .rxdPin(rxdLine), .txdPin(txdPin), .txdPinOe(txdPinOe),
    .irqReq(irqReq)
  );

  auart_remote remote
  (
    .sys_clk(sys_clk), .txdPin(txdPin), .txdPinOe(txdPinOe),
    .rxdLine(rxdLine)
  );

  // ====================
  // checking and bus tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic giveUp(input string what);
    err_total++;
    $display("mismatch %s expected answer seen timeout", what);
    final_report();
  endtask

  task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge sys_clk);
      if (awReady)
        awValid <= 1'b0;
      if (wReady)
        wValid <= 1'b0;
      if (bValid)
        break;
    end
    wrResp = bResp;
    bReady <= 1'b0;
    if (n == 64)
      giveUp("write");
  endtask

  task automatic busRead(input logic [7:0] a);
    @(posedge sys_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge sys_clk);
      if (arReady)
        arValid <= 1'b0;
      if (rValid)
        break;
    end
    rv = rData;
    rr = rResp;
    rReady <= 1'b0;
    if (n == 64)
      giveUp("read");
  endtask

  task automatic waitFlag(input logic [31:0] m);
    int k;
    for (k = 0; k < 100; k++)
    begin
      busRead(`AUART_OFS_FLAGS);
      if ((rv & m) === m)
        break;
    end
    if (k == 100)
      giveUp("flag");
  endtask

  task automatic waitStart();
    for (n = 0; n < 400 && txdPin !== 1'b0; n++)
      @(posedge sys_clk);
    if (n == 400)
      giveUp("start bit");
  endtask

  task automatic waitTx(input int k);
    for (n = 0; n < 1000 && remote.gotData.size() < k; n++)
      @(posedge sys_clk);
    if (n == 1000)
      giveUp("frame");
  endtask

  // ====================
  // main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    check("txd in reset", 32'(txdPin), 32'h1);
    check("oe in reset", 32'(txdPinOe), 32'h0);
    rst_n <= 1'b1;
    busRead(`AUART_OFS_FLAGS);
    check("flags reset", rv, 32'hc0);
    foreach (rows[i])
    begin
      busWrite(rows[i].addr, rows[i].wr);
      check("bresp", 32'(wrResp), 32'(rows[i].resp));
      busRead(rows[i].addr);
      check("rdata", rv, rows[i].rd);
      check("rresp", 32'(rr), 32'(rows[i].resp));
      check("irq", 32'(irqReq), 32'(rows[i].irq));
    end
    // transmit: preamble first, then a second character queued
    busWrite(`AUART_OFS_CTRL2, 32'h08);
    busWrite(`AUART_OFS_DATA, 32'ha5);
    waitStart();
    check("preamble", 32'(n >= 150), 32'h1);
    busRead(`AUART_OFS_FLAGS);
    check("tx empty", rv & 32'hc0, 32'h80);
    busWrite(`AUART_OFS_DATA, 32'h3c);
    busRead(`AUART_OFS_FLAGS);
    check("tx queued", rv & 32'hc0, 32'h00);
    waitTx(2);
    repeat (24) @(posedge sys_clk);
    busRead(`AUART_OFS_FLAGS);
    check("tx done", rv & 32'hc0, 32'hc0);
    check("char a", 32'(remote.gotData[0]), 32'ha5);
    check("char b", 32'(remote.gotData[1]), 32'h3c);
    check("stops", 32'({remote.gotStop[0], remote.gotStop[1]}), 32'h3);
    // disable in mid character
    busWrite(`AUART_OFS_DATA, 32'h81);
    waitStart();
    busWrite(`AUART_OFS_CTRL2, 32'h00);
    check("oe held", 32'(txdPinOe), 32'h1);
    waitTx(3);
    repeat (24) @(posedge sys_clk);
    check("oe off", 32'(txdPinOe), 32'h0);
    check("char c", 32'(remote.gotData[2]), 32'h81);
    // nine-bit frame: the ninth captured bit is the low extra bit
    busWrite(`AUART_OFS_CTRL1, 32'h10);
    busWrite(`AUART_OFS_CTRL2, 32'h08);
    busWrite(`AUART_OFS_DATA, 32'h96);
    waitTx(4);
    check("nine data", 32'(remote.gotData[3]), 32'h96);
    check("ninth bit", 32'(remote.gotStop[3]), 32'h0);
    busWrite(`AUART_OFS_CTRL1, 32'h00);
    // receive: clean, idle, framing error, overrun
    busWrite(`AUART_OFS_CTRL2, 32'h04);
    remote.sendChar(8'h5a, 1'b1);
    waitFlag(32'h20);
    check("rx flags", rv & 32'h2e, 32'h20);
    busRead(`AUART_OFS_DATA);
    check("rx data", rv, 32'h5a);
    repeat (200) @(posedge sys_clk);
    busRead(`AUART_OFS_FLAGS);
    check("rx idle", rv & 32'h30, 32'h10);
    busWrite(`AUART_OFS_FLAGS, 32'h10);
    remote.sendChar(8'h33, 1'b0);
    waitFlag(32'h20);
    check("frame flags", rv & 32'h2e, 32'h22);
    busRead(`AUART_OFS_DATA);
    check("frame data", rv, 32'h33);
    busWrite(`AUART_OFS_FLAGS, 32'h02);
    remote.sendChar(8'hc1, 1'b1);
    remote.sendChar(8'hc2, 1'b1);
    waitFlag(32'h08);
    busRead(`AUART_OFS_DATA);
    check("overrun data", rv, 32'hc1);
    busWrite(`AUART_OFS_FLAGS, 32'h08);
    remote.sendChar(8'h00, 1'b0);
    waitFlag(32'h20);
    check("break flags", rv & 32'h2e, 32'h22);
    busRead(`AUART_OFS_DATA);
    check("break data", rv, 32'h00);
    busWrite(`AUART_OFS_FLAGS, 32'h02);
    // sleep: address-mark wake, then idle-line wake
    busWrite(`AUART_OFS_CTRL1, 32'h08);
    busWrite(`AUART_OFS_CTRL2, 32'h06);
    remote.sendChar(8'h12, 1'b1);
    repeat (8) @(posedge sys_clk);
    busRead(`AUART_OFS_FLAGS);
    check("sleep flags", rv & 32'h2e, 32'h00);
    remote.sendChar(8'h85, 1'b1);
    waitFlag(32'h20);
    busRead(`AUART_OFS_DATA);
    check("addr data", rv, 32'h85);
    busRead(`AUART_OFS_CTRL2);
    check("addr wake", rv, 32'h04);
    busWrite(`AUART_OFS_CTRL1, 32'h00);
    busWrite(`AUART_OFS_CTRL2, 32'h06);
    remote.sendChar(8'h11, 1'b1);
    busRead(`AUART_OFS_CTRL2);
    check("still asleep", rv, 32'h06);
    repeat (200) @(posedge sys_clk);
    busRead(`AUART_OFS_CTRL2);
    check("idle wake", rv, 32'h04);
    busRead(`AUART_OFS_FLAGS);
    check("no rx flag", rv & 32'h20, 32'h00);
    final_report();
  end
endmodule
